//--- inc/srlc_regs.vh
// register map and field layout of the receive lane configuration bank
// assumes inclusion by the single design module of this bank
`ifndef SRLC_REGS_VH
`define SRLC_REGS_VH

// byte addresses of the lane registers
`define SRLC_LANE0_OFFSET 12'h100
`define SRLC_LANE1_OFFSET 12'h104
`define SRLC_ADDR_W 12
`define SRLC_LANE_STRIDE 12'h004

// field positions
`define SRLC_RSVD_HI_MSB 31
`define SRLC_RSVD_HI_LSB 26
`define SRLC_RSVD_WR_MSB 25
`define SRLC_RSVD_WR_LSB 24
`define SRLC_RSVD_MID_BIT 23
`define SRLC_EQ_MSB 22
`define SRLC_EQ_LSB 19
`define SRLC_LOOP_MSB 18
`define SRLC_LOOP_LSB 16
`define SRLC_LOSS_MSB 15
`define SRLC_LOSS_LSB 14
`define SRLC_LOW_MSB 13
`define SRLC_LOW_LSB 0

// writable bits: 25..24, 22..14 and the low fields 13..0 stored as written
`define SRLC_WR_MASK 32'h037fffff

// reset value of every lane register
`define SRLC_RESET_VAL 32'h00000000

// signal loss detect codes
`define SRLC_LOSS_OFF 2'h0
`define SRLC_LOSS_HIGH 2'h1
`define SRLC_LOSS_LOW 2'h2
`define SRLC_LOSS_RSVD 2'h3

// recovery loop codes
`define SRLC_LOOP_FIRST 3'h0
`define SRLC_LOOP_FIRST_FAST 3'h4

// bus answers
`define SRLC_ERR_READ 32'h00000000
`define SRLC_RESP_OK 2'h0
`define SRLC_RESP_SLVERR 2'h2

`endif

//--- rtl/srlc_rx_lane_config_regs.v
// receive lane configuration bank: one register per port, fields driven to the analog receivers
// assumes an avalon-mm master on clk_sys with word-aligned byte addresses
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "srlc_regs.vh"

// Behaviour
// - each port has its own configuration register, port 0 at 0x100 and port 1 at 0x104, steering only that port.
// - bits 31 to 26 read back as zero whatever is written.
// - bit 23 reads back as zero.
// - bits 22 to 19 are a four-bit equalizer setting taking any code.
// - recovery loop code 000 picks the first-order loop with narrow phase tracking.
// - codes 001, 010 and 011 pick second-order loops from most precise to fastest lock.
// - code 100 picks a first-order fast-lock loop with wide tracking during a training pattern.
// - codes 101, 110 and 111 are fast-lock versions of 001, 010 and 011.
// - signal loss detect code 00 disables loss of signal detection.
// - signal loss code 01 is the high threshold, 10 the low one, and 11 is reserved and not to be written.
module srlc_rx_lane_config_regs #(
   parameter NUM_LANES = 2
) (
   input wire clk_sys,
   input wire reset,
   input wire [`SRLC_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   output reg [1:0] avs_response,
   output wire [NUM_LANES*4-1:0] equalizer_setting,
   output wire [NUM_LANES*3-1:0] recovery_loop_select,
   output wire [NUM_LANES*2-1:0] signal_loss_detect_select,
   output wire [NUM_LANES-1:0] signal_loss_detect_enable,
   output wire [NUM_LANES-1:0] recovery_loop_first_order,
   output wire [NUM_LANES-1:0] recovery_loop_fast_lock,
   output wire [NUM_LANES*14-1:0] rx_lane_low_fields
);

   // one wait cycle per access: request taken on the second edge, readdata valid there
   reg ack_q;
   wire req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;

   reg [31:0] lane_q [0:NUM_LANES-1];
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // decode: lane n at lane0 offset + 4n; lanes beyond 1 follow the same stride
   reg hit;
   reg [31:0] rd_mux;
   integer k;
   always @* begin
      hit = 1'b0;
      rd_mux = `SRLC_ERR_READ;
      for (k = 0; k < NUM_LANES; k = k + 1) begin
         if (avs_address == (`SRLC_LANE0_OFFSET + k[`SRLC_ADDR_W-1:0] * `SRLC_LANE_STRIDE)) begin
            hit = 1'b1;
            rd_mux = lane_q[k] & `SRLC_WR_MASK;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (reset) begin
         ack_q <= 1'b0;
         avs_readdata <= `SRLC_ERR_READ;
         avs_response <= `SRLC_RESP_OK;
      end else begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q) begin
            avs_readdata <= avs_read ? rd_mux : `SRLC_ERR_READ;
            avs_response <= hit ? `SRLC_RESP_OK : `SRLC_RESP_SLVERR;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_LANES; g = g + 1) begin : g_lane
         localparam [`SRLC_ADDR_W-1:0] LANE_ADDR = `SRLC_LANE0_OFFSET + g * `SRLC_LANE_STRIDE;
         wire sel = (avs_address == LANE_ADDR);
         wire [2:0] loop_code = lane_q[g][`SRLC_LOOP_MSB:`SRLC_LOOP_LSB];
         wire [1:0] loss_code = lane_q[g][`SRLC_LOSS_MSB:`SRLC_LOSS_LSB];
         always @(posedge clk_sys) begin
            if (reset) begin
               lane_q[g] <= `SRLC_RESET_VAL;
            end else if (avs_write & ack_q & sel) begin
               // write lands only at the edge where waitrequest is seen low
               // read-only bits never store; bits 25..24 store as written, software keeps them zero
               lane_q[g] <= (lane_q[g] & ~(be_mask & `SRLC_WR_MASK)) |
                            (avs_writedata & be_mask & `SRLC_WR_MASK);
            end
         end
         assign equalizer_setting[g*4 +: 4] = lane_q[g][`SRLC_EQ_MSB:`SRLC_EQ_LSB];
         assign recovery_loop_select[g*3 +: 3] = loop_code;
         // codes 000 and 100 are first order, msb set marks fast lock
         assign recovery_loop_first_order[g] =
            (loop_code == `SRLC_LOOP_FIRST) | (loop_code == `SRLC_LOOP_FIRST_FAST);
         assign recovery_loop_fast_lock[g] = loop_code[2];
         assign signal_loss_detect_select[g*2 +: 2] = loss_code;
         // reserved code 11 is treated as disabled so a bad write cannot arm detection
         assign signal_loss_detect_enable[g] =
            (loss_code == `SRLC_LOSS_HIGH) | (loss_code == `SRLC_LOSS_LOW);
         assign rx_lane_low_fields[g*14 +: 14] = lane_q[g][`SRLC_LOW_MSB:`SRLC_LOW_LSB];
      end
   endgenerate

endmodule // srlc_rx_lane_config_regs
`default_nettype wire

//--- test/srlc_checker.sv
// checker of bus timing and field decode of the lane bank
// assumes a bind to the bank top module
`timescale 1ns/1ps
`default_nettype none
module srlc_checker #(parameter NUM_LANES = 2) (input wire clk_sys, reset, avs_read, avs_write, avs_waitrequest,
   input wire [31:0] avs_readdata, input wire [NUM_LANES*3-1:0] recovery_loop_select,
   input wire [NUM_LANES*2-1:0] signal_loss_detect_select, input wire [NUM_LANES-1:0] signal_loss_detect_enable,
   input wire [NUM_LANES-1:0] recovery_loop_first_order, recovery_loop_fast_lock);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire rd = avs_read && !avs_waitrequest;
   wire wr = avs_write && !avs_waitrequest;
   property p_ws; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
   a_ws: assert property (p_ws) else $error("wait state");
   property p_rz; rd |-> avs_readdata[31:26] == 6'h0 && !avs_readdata[23]; endproperty
   a_rz: assert property (p_rz) else $error("reserved bit");
   property p_hl; !wr |=> $stable(recovery_loop_select); endproperty
   a_hl: assert property (p_hl) else $error("loop moved");
   property p_hs; !wr |=> $stable(signal_loss_detect_select); endproperty
   a_hs: assert property (p_hs) else $error("loss moved");
   property p_fo; recovery_loop_first_order[0] == (recovery_loop_select[1:0] == 2'h0); endproperty
   a_fo: assert property (p_fo) else $error("first order");
   property p_fl; recovery_loop_fast_lock[0] == recovery_loop_select[2]; endproperty
   a_fl: assert property (p_fl) else $error("fast lock");
   property p_f1; recovery_loop_fast_lock[1] == recovery_loop_select[5]; endproperty
   a_f1: assert property (p_f1) else $error("lane 1 lock");
   property p_lo; signal_loss_detect_enable[0] == ^signal_loss_detect_select[1:0]; endproperty
   a_lo: assert property (p_lo) else $error("loss enable");
   c_wr: cover property (wr);
   c_rd: cover property (rd);
   c_fl: cover property (recovery_loop_fast_lock[1]);
endmodule // srlc_checker
bind srlc_rx_lane_config_regs srlc_checker #(.NUM_LANES(NUM_LANES)) i_chk (.*);
`default_nettype wire

//--- test/tb_srlc_rx_lane_config_regs.sv
// bench for the lane bank over avalon-mm
// assumes one wait state per access
`timescale 1ns/1ps
`default_nettype none
module tb_srlc_rx_lane_config_regs;
   logic clk_sys = 0, reset = 1, rd = 0, wr = 0, w;
   logic [11:0] ad = 0;
   logic [31:0] wd = 0, q, d;
   logic [1:0] rs, r, le, fo, fl;
   logic [7:0] eq;
   logic [5:0] lp;
   logic [3:0] ls, be = 4'hf;
   int fails = 0, cmp_count = 0;
   always #5 clk_sys = ~clk_sys;
   srlc_rx_lane_config_regs i_dut (.clk_sys, .reset, .avs_address(ad), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(q), .avs_waitrequest(w), .avs_response(rs),
      .equalizer_setting(eq), .recovery_loop_select(lp), .signal_loss_detect_select(ls),
      .signal_loss_detect_enable(le), .recovery_loop_first_order(fo), .recovery_loop_fast_lock(fl),
      .rx_lane_low_fields());
   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin fails++; $display("wrong value at %0t: %h not %h", $time, g, e); end
   endtask
   task automatic stop_test;
      $display("%0d checks, %0d wrong", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic wen, input logic [11:0] a, input logic [31:0] v);
      @(posedge clk_sys) {rd, wr, ad, wd} <= {!wen, wen, a, v};
      do @(posedge clk_sys); while (w !== 1'b0);
      {d, r} = {q, rs};
      {rd, wr} <= 2'h0;
   endtask
   task automatic t_map;
      bus(0, 12'h104, 0); chk(d, 0);
      bus(1, 12'h100, 32'hfcffbfff);
      bus(0, 12'h100, 0); chk(d, 32'h007fbfff);
      chk({eq, lp, ls, le, fo, fl}, 24'h0f1c99);
      bus(1, 12'h108, '1); bus(0, 12'h108, 0); chk({r, d[29:0]}, 32'h80000000);
      be <= 4'h4; bus(1, 12'h104, '1); be <= 4'hf;
      bus(0, 12'h104, 0); chk(d, 32'h007f0000);
      $display("map test done");
   endtask
   // loss code 11 is never written: software may not use it
   task automatic t_codes;
      for (int k = 0; k < 16; k++) begin
         bus(1, 12'h104, {9'h0, k[3:0], k[2:0], 2'(k % 3), 14'h0});
         bus(0, 12'h104, 0); chk(d[22:14], {k[3:0], k[2:0], 2'(k % 3)});
         chk({eq[7:4], lp[5:3], ls[3:2], le[1], fo[1], fl[1]},
            {k[3:0], k[2:0], 2'(k % 3), (k % 3) != 0, k[1:0] == 2'h0, k[2]});
      end
      bus(0, 12'h100, 0); chk(d, 32'h007fbfff);
      $display("code test done");
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 0;
      t_map; t_codes; stop_test;
   end
   initial begin #20us; fails++; stop_test; end
endmodule // tb_srlc_rx_lane_config_regs
`default_nettype wire
